// File: timer_mode_control.sv
// mode, prescale, output-level and event logic for one timer instance
// assumes a count core outside that reports reload and compare match
// and consumes the count tick, capture and restart pulses
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: timer counts only while enable bit 7 is set
// RULE2: toggle modes: output equals polarity when disabled, toggles on reload
// RULE3: counter mode counts selected input edge; output toggles after reload
// RULE4: single pwm: idle polarity, match drives inverse, reload drives polarity
// RULE5: capture and capture-restart capture count on selected input edge
// RULE6: gated mode counts while input active, interrupts on deassert edge
// RULE7: capture/compare starts on first selected edge, later edges capture
// RULE8: dual pwm: output and complement opposite, swap on match and reload
// RULE9: dual pwm delays each pin before it goes to its active level
// RULE10: three-bit dead time: zero none, else two to the code cycles
// RULE11: disabled output pin follows polarity bit regardless of direction
// RULE12: polarity write while running leaves output pin unchanged
// RULE13: prescaler divides by two to the power of bits 5:3
// RULE14: prescaler state cleared while timer disabled
// RULE15: mode is top bit plus bits 2:0, codes 0000 to 1010
// RULE16: mode top bit sits at bit 7 of control register zero
// RULE17: code 1010 comparator counter, code 1001 capture restart
// RULE18: mode codes above 1010 behave as one-shot
module timer_mode_control
   import timer_mode_control_pkg::*;
#(
   parameter int TIMER_INDEX = 0,
   parameter int PRESCALE_WIDTH = 7,
   parameter int DEADTIME_WIDTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic timer_in_i,
   input wire logic reload_event_i,
   input wire logic match_event_i,
   output logic count_tick_o,
   output logic capture_o,
   output logic restart_o,
   output logic timer_output_pin_o,
   output logic timer_output_n_o,
   output logic irq_o
);

   localparam logic [11:0] CTL1_OFS =
      (TIMER_INDEX == 0) ? TIMER0_CONTROL_ONE_OFS : TIMER1_CONTROL_ONE_OFS;
   localparam logic [11:0] CTL0_OFS =
      (TIMER_INDEX == 0) ? TIMER0_CONTROL_ZERO_OFS : TIMER1_CONTROL_ZERO_OFS;
   localparam logic [11:0] STAT_OFS =
      (TIMER_INDEX == 0) ? TIMER0_EVENT_STATUS_OFS : TIMER1_EVENT_STATUS_OFS;
   localparam logic [11:0] MASK_OFS =
      (TIMER_INDEX == 0) ? TIMER0_EVENT_MASK_OFS : TIMER1_EVENT_MASK_OFS;

   control_one_s ctl_one_q;
   control_zero_s ctl_zero_q;
   logic [EVT_COUNT-1:0] status_q;
   logic [EVT_COUNT-1:0] mask_q;
   logic [7:0] rdata_q;
   logic in_q;
   logic started_q;
   logic [PRESCALE_WIDTH-1:0] presc_q;
   logic tick_q;
   logic capture_q;
   logic restart_q;
   logic out_q;
   logic out_n_q;
   logic irq_q;
   deadtime_e dt_state_q;
   logic [DEADTIME_WIDTH-1:0] dt_cnt_q;
   logic dt_pin_q;

   mode_e mode;
   logic en;
   logic pol;
   logic rise;
   logic fall;
   logic sel_edge;
   logic opp_edge;
   logic gate_act;
   logic src;
   logic [PRESCALE_WIDTH-1:0] presc_mask;
   logic presc_wrap;
   logic evt_reload;
   logic evt_match;
   logic evt_capture;
   logic evt_gate_end;
   logic [EVT_COUNT-1:0] evt_vec;
   logic [EVT_COUNT-1:0] irq_sel;
   logic [DEADTIME_WIDTH-1:0] dt_len;
   logic wr_ctl1;
   logic wr_ctl0;
   logic wr_stat;
   logic wr_mask;

   // RULE15 mode from two registers
   function automatic mode_e decode_mode(input logic [3:0] code);
      // RULE18 undefined codes fall back
      if (code > 4'hA) begin
         return MODE_ONE_SHOT;
      end
      // RULE17 1001 and 1010 in same space
      return mode_e'(code);
   endfunction

   // RULE16 top bit from control zero
   assign mode = decode_mode({ctl_zero_q.op_select_top_bit,
                              ctl_one_q.op_select_low});
   assign en = ctl_one_q.timer_enable;
   assign pol = ctl_one_q.io_polarity;

   // register decode
   assign wr_ctl1 = reg_wr_i && (reg_addr_i == CTL1_OFS);
   assign wr_ctl0 = reg_wr_i && (reg_addr_i == CTL0_OFS);
   assign wr_stat = reg_wr_i && (reg_addr_i == STAT_OFS);
   assign wr_mask = reg_wr_i && (reg_addr_i == MASK_OFS);

   // input edges, pin is already synchronous
   assign rise = timer_in_i & ~in_q;
   assign fall = ~timer_in_i & in_q;
   // RULE3 polarity picks the edge
   assign sel_edge = pol ? fall : rise;
   assign opp_edge = pol ? rise : fall;
   // RULE6 gate active level
   assign gate_act = timer_in_i ^ pol;

   // count source per mode
   always_comb begin
      unique case (mode)
         // RULE3 count on input edges
         MODE_COUNTER: src = sel_edge;
         // RULE6 count while gate active
         MODE_GATED: src = gate_act;
         // RULE7 count after first edge
         MODE_CAPTURE_COMPARE: src = started_q;
         default: src = 1'b1;
      endcase
   end

   // RULE13 divide by 2^exponent
   assign presc_mask = PRESCALE_WIDTH'((8'h01 << ctl_one_q.clock_divider_exponent)
                                       - 8'h01);
   assign presc_wrap = (presc_q & presc_mask) == presc_mask;

   // events, all qualified by enable
   assign evt_reload = en & reload_event_i;
   assign evt_match = en & match_event_i;
   always_comb begin
      evt_capture = 1'b0;
      unique case (mode)
         // RULE5 capture on selected edge
         MODE_CAPTURE, MODE_CAPTURE_RESTART: evt_capture = en & sel_edge;
         // RULE7 later edges capture
         MODE_CAPTURE_COMPARE: evt_capture = en & sel_edge & started_q;
         default: evt_capture = 1'b0;
      endcase
   end
   // RULE6 interrupt on deassert edge
   assign evt_gate_end = en & (mode == MODE_GATED) & opp_edge;
   assign evt_vec = {evt_gate_end, evt_capture, evt_match, evt_reload};

   // interrupt source selection from control zero
   always_comb begin
      unique case (ctl_zero_q.irq_config)
         2'b10: irq_sel = 4'h0 | (4'h1 << EVT_CAPTURE) | (4'h1 << EVT_GATE_END);
         2'b11: irq_sel = 4'h0 | (4'h1 << EVT_RELOAD) | (4'h1 << EVT_MATCH);
         default: irq_sel = 4'hF;
      endcase
   end

   // RULE10 zero none, else 2^code
   assign dt_len = (ctl_zero_q.deadband_delay == 3'h0) ? '0 :
                   DEADTIME_WIDTH'(9'h001 << ctl_zero_q.deadband_delay);

   // control register one, software owned
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ctl_one_q <= control_one_s'(CONTROL_ONE_RST);
      end else if (wr_ctl1) begin
         ctl_one_q <= control_one_s'(reg_wdata_i);
      end
   end

   // control register zero; low bit is status only
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ctl_zero_q <= control_zero_s'(CONTROL_ZERO_RST);
      end else begin
         if (wr_ctl0) begin
            ctl_zero_q.op_select_top_bit <= reg_wdata_i[OP_TOP_BIT];
            ctl_zero_q.irq_config <= reg_wdata_i[6:5];
            ctl_zero_q.reserved <= reg_wdata_i[4];
            ctl_zero_q.deadband_delay <= reg_wdata_i[DEADBAND_LSB +: 3];
         end
         // most recent event was a capture or not
         if (evt_capture) begin
            ctl_zero_q.last_was_capture <= 1'b1;
         end else if (evt_reload | evt_match) begin
            ctl_zero_q.last_was_capture <= 1'b0;
         end
      end
   end

   // sticky status, write one clears, a new event wins
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         status_q <= EVENT_STATUS_RST[EVT_COUNT-1:0];
      end else if (wr_stat) begin
         status_q <= (status_q & ~reg_wdata_i[EVT_COUNT-1:0]) | evt_vec;
      end else begin
         status_q <= status_q | evt_vec;
      end
   end

   // interrupt mask
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mask_q <= EVENT_MASK_RST[EVT_COUNT-1:0];
      end else if (wr_mask) begin
         mask_q <= reg_wdata_i[EVT_COUNT-1:0];
      end
   end

   // level interrupt, registered so it is one cycle after status
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q & irq_sel);
      end
   end

   // read data stands the cycle after the strobe only
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            CTL1_OFS: rdata_q <= ctl_one_q;
            CTL0_OFS: rdata_q <= ctl_zero_q;
            STAT_OFS: rdata_q <= {4'h0, status_q};
            MASK_OFS: rdata_q <= {4'h0, mask_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // input history and capture/compare start flag
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         in_q <= 1'b0;
         started_q <= 1'b0;
      end else begin
         in_q <= timer_in_i;
         if (!en || mode != MODE_CAPTURE_COMPARE) begin
            started_q <= 1'b0;
         // RULE7 first edge starts counting
         end else if (sel_edge) begin
            started_q <= 1'b1;
         end
      end
   end

   // prescaler and count tick
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         presc_q <= '0;
         tick_q <= 1'b0;
      // RULE14 cleared while disabled
      end else if (!en) begin
         presc_q <= '0;
         tick_q <= 1'b0;
      // RULE1 advance only while enabled
      end else if (src) begin
         tick_q <= presc_wrap;
         presc_q <= presc_wrap ? '0 : presc_q + 1'b1;
      end else begin
         tick_q <= 1'b0;
      end
   end

   // capture and restart strobes toward the count core
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         capture_q <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         capture_q <= evt_capture;
         restart_q <= evt_capture & (mode == MODE_CAPTURE_RESTART);
      end
   end

   // output pins and dead-time sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         out_q <= 1'b0;
         out_n_q <= 1'b1;
         dt_state_q <= DT_IDLE;
         dt_cnt_q <= '0;
         dt_pin_q <= 1'b0;
      // RULE11 idle pins follow polarity
      end else if (!en) begin
         out_q <= pol;
         out_n_q <= ~pol;
         dt_state_q <= DT_IDLE;
         dt_cnt_q <= '0;
      end else begin
         // RULE12 polarity only used at events
         unique case (mode)
            // RULE4 match inverse, reload polarity
            MODE_PWM_SINGLE: begin
               if (evt_reload) begin
                  out_q <= pol;
               end else if (evt_match) begin
                  out_q <= ~pol;
               end
            end
            // RULE8 pins swap on match and reload
            MODE_PWM_DUAL: begin
               if (evt_reload || evt_match) begin
                  // inactive side moves at once
                  if (evt_reload) begin
                     out_q <= pol;
                  end else begin
                     out_n_q <= pol;
                  end
                  // RULE9 active side waits dead time
                  if (dt_len == '0) begin
                     if (evt_reload) begin
                        out_n_q <= ~pol;
                     end else begin
                        out_q <= ~pol;
                     end
                     dt_state_q <= DT_IDLE;
                  end else begin
                     dt_state_q <= DT_WAIT;
                     dt_cnt_q <= dt_len;
                     dt_pin_q <= evt_reload;
                  end
               end else if (dt_state_q == DT_WAIT) begin
                  if (dt_cnt_q == 1) begin
                     if (dt_pin_q) begin
                        out_n_q <= ~pol;
                     end else begin
                        out_q <= ~pol;
                     end
                     dt_state_q <= DT_IDLE;
                  end
                  dt_cnt_q <= dt_cnt_q - 1'b1;
               end
            end
            // RULE2 RULE3 toggle on each reload
            default: begin
               if (evt_reload) begin
                  out_q <= ~out_q;
               end
            end
         endcase
      end
   end

   assign reg_rdata_o = rdata_q;
   assign count_tick_o = tick_q;
   assign capture_o = capture_q;
   assign restart_o = restart_q;
   assign timer_output_pin_o = out_q;
   assign timer_output_n_o = out_n_q;
   assign irq_o = irq_q;

endmodule // timer_mode_control

`default_nettype wire

// File: timer_mode_control_pkg.sv
// constants, field layouts and mode codes for the timer mode/control block
// assumes an 8-bit register port with 12-bit byte addresses
`default_nettype none

package timer_mode_control_pkg;

   // printed register offsets, per timer instance
   localparam logic [11:0] TIMER0_CONTROL_ONE_OFS = 12'hF07;
   localparam logic [11:0] TIMER1_CONTROL_ONE_OFS = 12'hF0F;
   localparam logic [11:0] TIMER0_CONTROL_ZERO_OFS = 12'hF06;
   localparam logic [11:0] TIMER1_CONTROL_ZERO_OFS = 12'hF0E;
   // event status and mask registers
   localparam logic [11:0] TIMER0_EVENT_STATUS_OFS = 12'hF18;
   localparam logic [11:0] TIMER0_EVENT_MASK_OFS = 12'hF19;
   localparam logic [11:0] TIMER1_EVENT_STATUS_OFS = 12'hF1A;
   localparam logic [11:0] TIMER1_EVENT_MASK_OFS = 12'hF1B;

   // field positions
   localparam int ENABLE_BIT = 7;
   localparam int POLARITY_BIT = 6;
   localparam int DIVIDER_LSB = 3;
   localparam int OP_LOW_LSB = 0;
   localparam int OP_TOP_BIT = 7;
   localparam int DEADBAND_LSB = 1;

   // reset values
   localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
   localparam logic [7:0] CONTROL_ZERO_RST = 8'h00;
   localparam logic [7:0] EVENT_STATUS_RST = 8'h00;
   localparam logic [7:0] EVENT_MASK_RST = 8'h00;

   // event status bit positions
   localparam int EVT_RELOAD = 0;
   localparam int EVT_MATCH = 1;
   localparam int EVT_CAPTURE = 2;
   localparam int EVT_GATE_END = 3;
   localparam int EVT_COUNT = 4;

   typedef struct packed {
      logic timer_enable;
      logic io_polarity;
      logic [2:0] clock_divider_exponent;
      logic [2:0] op_select_low;
   } control_one_s;

   typedef struct packed {
      logic op_select_top_bit;
      logic [1:0] irq_config;
      logic reserved;
      logic [2:0] deadband_delay;
      logic last_was_capture;
   } control_zero_s;

   typedef enum logic [3:0] {
      MODE_ONE_SHOT = 4'h0,
      MODE_CONTINUOUS = 4'h1,
      MODE_COUNTER = 4'h2,
      MODE_PWM_SINGLE = 4'h3,
      MODE_CAPTURE = 4'h4,
      MODE_COMPARE = 4'h5,
      MODE_GATED = 4'h6,
      MODE_CAPTURE_COMPARE = 4'h7,
      MODE_PWM_DUAL = 4'h8,
      MODE_CAPTURE_RESTART = 4'h9,
      MODE_COMPARATOR_COUNTER = 4'hA
   } mode_e;

   // dead-time sequencer states, gray along idle -> wait
   typedef enum logic [1:0] {
      DT_IDLE = 2'b00,
      DT_WAIT = 2'b01
   } deadtime_e;

endpackage : timer_mode_control_pkg

`default_nettype wire

// File: timer_mode_control_props.sv
// assertions on the ports of the timer mode/control block
// assumes a bind to timer_mode_control with its timer index
`timescale 1ns/1ps
`default_nettype none
module timer_mode_control_props
   import timer_mode_control_pkg::*;
#(
   parameter int TIMER_INDEX = 0
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic timer_in_i,
   input wire logic reload_event_i,
   input wire logic match_event_i,
   input wire logic count_tick_o,
   input wire logic capture_o,
   input wire logic restart_o,
   input wire logic timer_output_pin_o,
   input wire logic timer_output_n_o,
   input wire logic irq_o
);
   logic [7:0] c1_q, c1_p_q, c1_pp_q, c0_q;
   logic [11:0] a1, a0;
   logic en, pol, calm, off;
   logic [3:0] mode;
   assign a1 = (TIMER_INDEX == 0) ? TIMER0_CONTROL_ONE_OFS : TIMER1_CONTROL_ONE_OFS;
   assign a0 = (TIMER_INDEX == 0) ? TIMER0_CONTROL_ZERO_OFS : TIMER1_CONTROL_ZERO_OFS;
   // shadow control registers and their history
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         c1_q <= 8'h00;
         c1_p_q <= 8'h00;
         c1_pp_q <= 8'h00;
         c0_q <= 8'h00;
      end else begin
         c1_p_q <= c1_q;
         c1_pp_q <= c1_p_q;
         if (reg_wr_i && reg_addr_i == a1) begin
            c1_q <= reg_wdata_i;
         end
         if (reg_wr_i && reg_addr_i == a0) begin
            c0_q <= reg_wdata_i;
         end
      end
   end
   // settled view of the settings
   assign en = c1_q[ENABLE_BIT];
   assign pol = c1_q[POLARITY_BIT];
   assign mode = {c0_q[OP_TOP_BIT], c1_q[2:0]};
   assign calm = (c1_q == c1_p_q) && (c1_p_q == c1_pp_q);
   assign off = calm && !en;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside read cycle");
   a_quiet_off: assert property (
      off |-> !count_tick_o && !capture_o && !restart_o)
      else $error("activity while disabled");
   a_idle_level: assert property (
      off |-> timer_output_pin_o == pol && timer_output_n_o == !pol)
      else $error("idle pin level wrong");
   a_tick_div1: assert property (
      en && calm && c1_q[5:3] == 3'h0 && mode == MODE_CONTINUOUS |-> count_tick_o)
      else $error("missing tick at divide by one");
   a_toggle_reload: assert property (
      en && calm && mode == MODE_CONTINUOUS && reload_event_i
      |=> timer_output_pin_o != $past(timer_output_pin_o))
      else $error("no toggle on reload");
   a_pwm_match: assert property (
      en && calm && mode == MODE_PWM_SINGLE && match_event_i && !reload_event_i
      |=> timer_output_pin_o == !pol)
      else $error("pwm match level wrong");
   a_pwm_reload: assert property (
      en && calm && mode == MODE_PWM_SINGLE && reload_event_i |=> timer_output_pin_o == pol)
      else $error("pwm reload level wrong");
   a_capture_edge: assert property (
      en && calm && mode == MODE_CAPTURE && timer_in_i != pol
      && timer_in_i != $past(timer_in_i) |=> capture_o)
      else $error("missing capture");
   a_dead_time: assert property (
      en && calm && mode == MODE_PWM_DUAL && c0_q[3:1] == 3'h1 && !pol && match_event_i
      && !reload_event_i |=> !timer_output_n_o && !timer_output_pin_o
      ##1 !timer_output_pin_o ##1 timer_output_pin_o)
      else $error("dead time wrong");
   c_match: cover property (en && match_event_i);
   c_capture: cover property (capture_o);
   c_irq: cover property ($rose(irq_o));
endmodule // timer_mode_control_props
`default_nettype wire

// File: timer_pin_model.sv
// model of the input pin and of the count core events
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
   input wire logic sys_clk_i,
   output logic timer_in_o,
   output logic reload_o,
   output logic match_o
);
   // quiet pin and no events at time zero
   initial begin
      timer_in_o = 1'b0;
      reload_o = 1'b0;
      match_o = 1'b0;
   end
   // one-cycle event pulse, as the count core gives
   task automatic ev(input logic rel, input logic mat);
      @(posedge sys_clk_i);
      reload_o <= rel;
      match_o <= mat;
      @(posedge sys_clk_i);
      reload_o <= 1'b0;
      match_o <= 1'b0;
   endtask
   // input pin level, changed on the clock
   task automatic pin(input logic lvl);
      @(posedge sys_clk_i);
      timer_in_o <= lvl;
   endtask
endmodule // timer_pin_model
`default_nettype wire

// File: timer_mode_control_tb.sv
// self-checking bench for the timer mode/control block, timer 0 map
// assumes the pin model stands in for the pin and the count core
`timescale 1ns/1ps
`default_nettype none
module timer_mode_control_tb;
   import timer_mode_control_pkg::*;
   localparam logic [11:0] C1 = TIMER0_CONTROL_ONE_OFS;
   localparam logic [11:0] C0 = TIMER0_CONTROL_ZERO_OFS;
   localparam logic [11:0] ST = TIMER0_EVENT_STATUS_OFS;
   localparam logic [11:0] MK = TIMER0_EVENT_MASK_OFS;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, cnt, outv, pins, irqv;
   logic timer_in, reload_ev, match_ev, count_tick, capture, restart, out_pin, out_n, irq, v;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   // pins widened for the byte compare
   assign outv = {7'h00, out_pin};
   assign pins = {6'h00, out_pin, out_n};
   assign irqv = {7'h00, irq};
   always #20 sys_clk = ~sys_clk;
   timer_mode_control #(.TIMER_INDEX(0)) i_timer_mode_control (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .timer_in_i(timer_in),
      .reload_event_i(reload_ev), .match_event_i(match_ev), .count_tick_o(count_tick),
      .capture_o(capture), .restart_o(restart), .timer_output_pin_o(out_pin),
      .timer_output_n_o(out_n), .irq_o(irq));
   timer_pin_model i_timer_pin_model (.sys_clk_i(sys_clk), .timer_in_o(timer_in),
      .reload_o(reload_ev), .match_o(match_ev));
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask
   // one-cycle strobes; read data the cycle after
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp, what);
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   // pulse counter: 0 tick, 1 capture, 2 restart
   task automatic count(input int k, input int sel, output logic [7:0] c);
      c = 8'h00;
      repeat (k) begin
         @(posedge sys_clk);
         #1;
         if (((sel == 0) ? count_tick : (sel == 1) ? capture : restart) === 1'b1) begin
            c = c + 8'h01;
         end
      end
   endtask
   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         $display("CHECK FAILED at %0t: timeout", $time);
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(C1, 8'h00, "ctl1 reset");
      rd(C0, 8'h00, "ctl0 reset");
      rd(12'hF00, 8'h00, "unmapped");
      wr(C1, 8'h7F);
      wr(C0, 8'hFF);
      rd(C1, 8'h7F, "ctl1 rw");
      rd(C0, 8'hFE, "ctl0 rw");
      wr(C0, 8'h00);
      wr(C1, 8'h00);
      $display("done registers");
      // divide by 128, then a fresh restart
      wr(C1, 8'hB9);
      idle(4);
      count(256, 0, cnt);
      check(cnt, 8'h02, "div 128");
      wr(C1, 8'h39);
      idle(2);
      wr(C1, 8'hB9);
      count(120, 0, cnt);
      check(cnt, 8'h00, "fresh start");
      count(20, 0, cnt);
      check(cnt, 8'h01, "first tick");
      wr(C1, 8'h81);
      idle(3);
      count(20, 0, cnt);
      check(cnt, 8'h14, "div 1");
      wr(C1, 8'h01);
      idle(3);
      count(20, 0, cnt);
      check(cnt, 8'h00, "stopped");
      $display("done prescale");
      // two rising edges, one falling
      for (int p = 0; p < 2; p++) begin
         i_timer_pin_model.pin(1'b0);
         wr(C1, {1'b1, p[0], 6'h02});
         idle(3);
         fork
            count(12, 0, cnt);
            begin
               i_timer_pin_model.pin(1'b1);
               idle(2);
               i_timer_pin_model.pin(1'b0);
               idle(2);
               i_timer_pin_model.pin(1'b1);
            end
         join
         check(cnt, 8'(2 - p), "edge count");
      end
      $display("done counter");
      wr(C1, 8'h41);
      idle(3);
      check(outv, 8'h01, "idle level");
      wr(C1, 8'hC1);
      wr(C1, 8'h81);
      idle(3);
      check(outv, 8'h01, "polarity write");
      i_timer_pin_model.ev(1'b1, 1'b0);
      idle(1);
      check(outv, 8'h00, "reload toggle");
      wr(C0, 8'h80);
      wr(C1, 8'h83);
      idle(3);
      v = out_pin;
      i_timer_pin_model.ev(1'b1, 1'b0);
      idle(1);
      check(outv, {7'h00, ~v}, "undefined mode");
      wr(C1, 8'h03);
      wr(C0, 8'h00);
      $display("done toggle");
      for (int p = 0; p < 2; p++) begin
         wr(C1, {1'b0, p[0], 6'h03});
         idle(3);
         check(outv, 8'(p), "pwm idle");
         wr(C1, {1'b1, p[0], 6'h03});
         idle(3);
         i_timer_pin_model.ev(1'b0, 1'b1);
         idle(1);
         check(outv, 8'(1 - p), "pwm match");
         i_timer_pin_model.ev(1'b1, 1'b0);
         idle(1);
         check(outv, 8'(p), "pwm reload");
      end
      $display("done pwm single");
      // dual output: code 001 then code 111 dead time
      wr(C1, 8'h00);
      wr(C0, 8'h82);
      idle(3);
      check(pins, 8'h01, "dual idle");
      wr(C1, 8'h80);
      idle(3);
      i_timer_pin_model.ev(1'b0, 1'b1);
      #1 check(pins, 8'h00, "match c1");
      idle(1);
      check(pins, 8'h00, "match c2");
      idle(1);
      check(pins, 8'h02, "match c3");
      wr(C0, 8'h8E);
      idle(3);
      i_timer_pin_model.ev(1'b1, 1'b0);
      #1 check(pins, 8'h00, "reload c1");
      idle(127);
      check(pins, 8'h00, "reload c128");
      idle(1);
      check(pins, 8'h01, "reload c129");
      wr(C1, 8'h40);
      idle(3);
      check(pins, 8'h02, "dual idle inv");
      $display("done pwm dual");
      // capture and capture-restart
      for (int m = 0; m < 2; m++) begin
         for (int p = 0; p < 2; p++) begin
            i_timer_pin_model.pin(1'b0);
            wr(C0, (m == 1) ? 8'h80 : 8'h00);
            wr(C1, {1'b1, p[0], 3'h0, (m == 1) ? 3'h1 : 3'h4});
            idle(3);
            i_timer_pin_model.pin(1'b1);
            count(4, m + 1, cnt);
            check(cnt, 8'(1 - p), "rising capture");
            i_timer_pin_model.pin(1'b0);
            count(4, m + 1, cnt);
            check(cnt, 8'(p), "falling capture");
         end
      end
      wr(C0, 8'h00);
      wr(C1, 8'h87);
      i_timer_pin_model.pin(1'b1);
      count(4, 1, cnt);
      check(cnt, 8'h00, "first edge");
      i_timer_pin_model.pin(1'b0);
      i_timer_pin_model.pin(1'b1);
      count(4, 1, cnt);
      check(cnt, 8'h01, "later edge");
      $display("done capture");
      // gate end through status and mask
      wr(C1, 8'h06);
      wr(C0, 8'h00);
      wr(ST, 8'h0F);
      wr(MK, 8'h08);
      i_timer_pin_model.pin(1'b1);
      wr(C1, 8'h86);
      idle(3);
      count(10, 0, cnt);
      check(cnt, 8'h0A, "gate open");
      check(irqv, 8'h00, "no irq");
      i_timer_pin_model.pin(1'b0);
      idle(3);
      check(irqv, 8'h01, "gate end irq");
      count(10, 0, cnt);
      check(cnt, 8'h00, "gate shut");
      rd(ST, 8'h08, "status");
      wr(ST, 8'h08);
      idle(2);
      check(irqv, 8'h00, "irq cleared");
      wr(MK, 8'h00);
      i_timer_pin_model.pin(1'b1);
      i_timer_pin_model.pin(1'b0);
      idle(3);
      check(irqv, 8'h00, "irq masked");
      rd(ST, 8'h08, "masked status");
      $display("done gated");
      test_done();
   end
endmodule // timer_mode_control_tb
bind timer_mode_control timer_mode_control_props #(.TIMER_INDEX(TIMER_INDEX)) u_props (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .timer_in_i(timer_in_i), .reload_event_i(reload_event_i),
   .match_event_i(match_event_i), .count_tick_o(count_tick_o), .capture_o(capture_o),
   .restart_o(restart_o), .timer_output_pin_o(timer_output_pin_o),
   .timer_output_n_o(timer_output_n_o), .irq_o(irq_o));
`default_nettype wire
